// >>> inc/put_defines.vh
`ifndef PUT_DEFINES_VH
`define PUT_DEFINES_VH

// Register byte offsets
`define PUT_REG_CTRL        12'h000
`define PUT_REG_EXTEND      12'h004
`define PUT_REG_COORD       12'h008
`define PUT_REG_STATUS      12'h00c
`define PUT_REG_IRQ_STAT    12'h010
`define PUT_REG_IRQ_EN      12'h014
`define PUT_REG_IRQ_CLR     12'h018

// Control fields
`define PUT_CTRL_OP_BIT     0
`define PUT_CTRL_SCH_LSB    1
`define PUT_CTRL_WS_LSB     3

// Scheme select codes
`define PUT_SCH_UNDER       2'h0
`define PUT_SCH_OVER        2'h1
`define PUT_SCH_BLOCK       2'h2

// Weak source mode codes
`define PUT_WS_OFF          2'h0
`define PUT_WS_RETURN       2'h1
`define PUT_WS_TRIP         2'h2
`define PUT_WS_BOTH         2'h3

// Reset values
`define PUT_CTRL_RST        5'h00
`define PUT_EXTEND_RST      16'h0000
`define PUT_COORD_RST       16'h0000

// Tick timing
`define PUT_TICK_MS         1
`define PUT_CLK_KHZ         100000
`define PUT_TICK_CYC        (`PUT_TICK_MS * `PUT_CLK_KHZ)

// Interrupt bit positions
`define PUT_IRQ_TRIP        0
`define PUT_IRQ_SEND        1
`define PUT_IRQ_RECV        2

`endif

// >>> core/put_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "put_defines.vh"

module put_tick #(
	parameter integer TICK_CYC = `PUT_TICK_CYC
) (
	// Clock and reset
	input  wire clk_i,
	input  wire sys_rst_i,
	input  wire ce_i,
	// Tick
	output reg  tick_o
);
	reg [31:0] cnt;

	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt    <= 32'h00000000;
			tick_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (cnt == TICK_CYC - 1)
			begin
				cnt    <= 32'h00000000;
				tick_o <= 1'b1;
			end
			else
			begin
				cnt    <= cnt + 32'h00000001;
				tick_o <= 1'b0;
			end
		end
	end
endmodule // put_tick

`default_nettype wire

// >>> core/put_hold.v
`timescale 1ns/1ps
`default_nettype none
`include "put_defines.vh"

// Ms timer: 'extend' mode holds out after in drops; otherwise delays rise.
module put_hold (
	// Clock and reset
	input  wire        clk_i,
	input  wire        sys_rst_i,
	input  wire        ce_i,
	input  wire        clr_i,
	input  wire        tick_i,
	// Control
	input  wire        extend_i,
	input  wire [15:0] time_i,
	input  wire        in_i,
	// Result
	output reg         out_o
);
	reg [15:0] cnt;

	always @(posedge clk_i)
	begin
		if (sys_rst_i || clr_i)
		begin
			cnt   <= 16'h0000;
			out_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (extend_i)
			begin
				if (in_i)
				begin
					cnt   <= 16'h0000;
					out_o <= 1'b1;
				end
				else if (out_o)
				begin
					if (cnt >= time_i)
						out_o <= 1'b0;
					else if (tick_i)
						cnt <= cnt + 16'h0001;
				end
			end
			else
			begin
				if (!in_i)
				begin
					cnt   <= 16'h0000;
					out_o <= 1'b0;
				end
				else if (cnt >= time_i)
					out_o <= 1'b1;
				else if (tick_i)
					cnt <= cnt + 16'h0001;
			end
		end
	end
endmodule // put_hold

`default_nettype wire

// >>> core/put_teleprot.v
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "put_defines.vh"

module put_teleprot #(
	parameter integer TICK_CYC = `PUT_TICK_CYC
) (
	// Clock, reset, enable
	input  wire        clk_i,
	input  wire        sys_rst_i,
	input  wire        ce_i,
	// AHB-Lite slave
	input  wire        hsel_i,
	input  wire [11:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg  [31:0] hrdata_o,
	output wire        hreadyout_o,
	output wire        hresp_o,
	// Local zones
	input  wire        short_zone_trip_in_i,
	input  wire [2:0]  short_zone_trip_phase_in_i,
	input  wire        long_zone_pickup_in_i,
	input  wire [2:0]  long_zone_pickup_phase_in_i,
	// Remote ends
	input  wire        recv_permit_end1_i,
	input  wire        recv_permit_end2_i,
	input  wire [2:0]  recv_permit_end1_phase_i,
	input  wire [2:0]  recv_permit_end2_phase_i,
	// Transmit
	output wire        send_permit_o,
	output wire [2:0]  send_permit_phase_o,
	// Event log copies
	output reg         recv_end1_o,
	output reg         recv_end2_o,
	output reg  [2:0]  recv_end1_phase_o,
	output reg  [2:0]  recv_end2_phase_o,
	// Trips
	output reg         trip_o,
	output wire [2:0]  phase_trip_out_o,
	// Mode decode
	output wire        return_en_o,
	output wire        weak_trip_en_o,
	// Interrupt
	output wire        irq_o
);
	// Pin synchronisers: first stage read only by second
	reg  [15:0] sync1;
	reg  [15:0] sync2;
	wire [15:0] pins = {
		short_zone_trip_in_i,
		short_zone_trip_phase_in_i,
		long_zone_pickup_in_i,
		long_zone_pickup_phase_in_i,
		recv_permit_end1_i,
		recv_permit_end2_i,
		recv_permit_end1_phase_i,
		recv_permit_end2_phase_i
	};

	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			sync1 <= 16'h0000;
			sync2 <= 16'h0000;
		end
		else if (ce_i)
		begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end

	wire       zt  = sync2[15];
	wire [2:0] ztp = sync2[14:12];
	wire       lp  = sync2[11];
	wire [2:0] lpp = sync2[10:8];
	wire       r1  = sync2[7];
	wire       r2  = sync2[6];
	wire [2:0] r1p = sync2[5:3];
	wire [2:0] r2p = sync2[2:0];

	// Configuration registers
	reg [4:0]  ctrl;
	reg [15:0] extend_time;
	reg [15:0] coordination_delay;
	reg [2:0]  irq_stat;
	reg [2:0]  irq_en;

	wire       op_on          = ctrl[`PUT_CTRL_OP_BIT];
	wire [1:0] scheme_select  = ctrl[`PUT_CTRL_SCH_LSB +: 2];
	wire [1:0] weak_source_mode = ctrl[`PUT_CTRL_WS_LSB +: 2];
	wire       underreach_permissive = op_on && (scheme_select == `PUT_SCH_UNDER);

	// Weak-source decode: a mode selects its own feature or both
	function ws_has;
		input [1:0] mode;
		input [1:0] code;
		begin
			ws_has = (mode == code) || (mode == `PUT_WS_BOTH);
		end
	endfunction

	assign return_en_o    = op_on && ws_has(weak_source_mode, `PUT_WS_RETURN);
	assign weak_trip_en_o = op_on && ws_has(weak_source_mode, `PUT_WS_TRIP);

	// Other schemes are not built here, so selecting one idles all timers
	wire clr = !underreach_permissive;
	wire tick;

	put_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.tick_o    (tick)
	);

	// Transmit: three-pole from zone trip or any phase, phases direct
	wire [3:0] send_raw = {zt | (|ztp), ztp};
	wire [3:0] send_ext;

	// Receive qualification per phase and three-pole
	wire [2:0] q_phase = (r1p | r2p | {3{r1 | r2}}) & lpp;
	wire       q_three = (r1 | r2) & lp;
	wire [3:0] trip_raw = {q_three, q_phase};
	wire [3:0] trip_dly;

	// Prolongation timers; the tick runs free, so a time may run up to one tick short
	put_hold u_ext_3p (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clr_i     (clr),
		.tick_i    (tick),
		.extend_i  (1'b1),
		.time_i    (extend_time),
		.in_i      (send_raw[3]),
		.out_o     (send_ext[3])
	);

	put_hold u_ext_a (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clr_i     (clr),
		.tick_i    (tick),
		.extend_i  (1'b1),
		.time_i    (extend_time),
		.in_i      (send_raw[0]),
		.out_o     (send_ext[0])
	);

	put_hold u_ext_b (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clr_i     (clr),
		.tick_i    (tick),
		.extend_i  (1'b1),
		.time_i    (extend_time),
		.in_i      (send_raw[1]),
		.out_o     (send_ext[1])
	);

	put_hold u_ext_c (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clr_i     (clr),
		.tick_i    (tick),
		.extend_i  (1'b1),
		.time_i    (extend_time),
		.in_i      (send_raw[2]),
		.out_o     (send_ext[2])
	);

	// Coordination timers, one per trip path
	put_hold u_crd_3p (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clr_i     (clr),
		.tick_i    (tick),
		.extend_i  (1'b0),
		.time_i    (coordination_delay),
		.in_i      (trip_raw[3]),
		.out_o     (trip_dly[3])
	);

	put_hold u_crd_a (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clr_i     (clr),
		.tick_i    (tick),
		.extend_i  (1'b0),
		.time_i    (coordination_delay),
		.in_i      (trip_raw[0]),
		.out_o     (trip_dly[0])
	);

	put_hold u_crd_b (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clr_i     (clr),
		.tick_i    (tick),
		.extend_i  (1'b0),
		.time_i    (coordination_delay),
		.in_i      (trip_raw[1]),
		.out_o     (trip_dly[1])
	);

	put_hold u_crd_c (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clr_i     (clr),
		.tick_i    (tick),
		.extend_i  (1'b0),
		.time_i    (coordination_delay),
		.in_i      (trip_raw[2]),
		.out_o     (trip_dly[2])
	);

	// Same permit feeds both remote channels outside
	assign send_permit_o       = send_ext[3];
	assign send_permit_phase_o = send_ext[2:0];
	assign phase_trip_out_o    = trip_dly[2:0];

	always @(posedge clk_i)
	begin
		if (sys_rst_i || (ce_i && clr))
		begin
			trip_o            <= 1'b0;
			recv_end1_o       <= 1'b0;
			recv_end2_o       <= 1'b0;
			recv_end1_phase_o <= 3'h0;
			recv_end2_phase_o <= 3'h0;
		end
		else if (ce_i)
		begin
			trip_o            <= trip_dly[3] | (|trip_dly[2:0]);
			recv_end1_o       <= r1;
			recv_end2_o       <= r2;
			recv_end1_phase_o <= r1p;
			recv_end2_phase_o <= r2p;
		end
	end

	// Interrupt events: rising edges of trip, send and receive
	reg        trip_q;
	reg        send_q;
	reg        recv_q;
	wire       recv_any = r1 | r2 | (|r1p) | (|r2p);
	wire [2:0] ev;

	// Edge flops reset to their sources' idle level, so reset raises no event
	assign ev[`PUT_IRQ_TRIP] = trip_o & ~trip_q;
	assign ev[`PUT_IRQ_SEND] = send_permit_o & ~send_q;
	assign ev[`PUT_IRQ_RECV] = recv_any & ~recv_q;

	// AHB-Lite: zero wait state, always OKAY
	reg        wr_pend;
	reg [11:0] wr_addr;
	wire       acc = hsel_i && htrans_i[1] && hready_i;
	// Only whole-word transfers are expected, so the size is not decoded

	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign irq_o       = |(irq_stat & irq_en);

	wire       wr_clr = wr_pend && (wr_addr == `PUT_REG_IRQ_CLR);

	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl               <= `PUT_CTRL_RST;
			extend_time        <= `PUT_EXTEND_RST;
			coordination_delay <= `PUT_COORD_RST;
			irq_stat           <= 3'h0;
			irq_en             <= 3'h0;
			wr_pend            <= 1'b0;
			wr_addr            <= 12'h000;
			hrdata_o           <= 32'h00000000;
			trip_q             <= 1'b0;
			send_q             <= 1'b0;
			recv_q             <= 1'b0;
		end
		else if (ce_i)
		begin
			trip_q  <= trip_o;
			send_q  <= send_permit_o;
			recv_q  <= recv_any;
			wr_pend <= acc && hwrite_i;
			wr_addr <= haddr_i;
			// Set wins over a simultaneous clear
			irq_stat <= (irq_stat & ~(wr_clr ? hwdata_i[2:0] : 3'h0)) | ev;
			if (wr_pend)
			begin
				case (wr_addr)
					`PUT_REG_CTRL:   ctrl <= hwdata_i[4:0];
					`PUT_REG_EXTEND: extend_time <= hwdata_i[15:0];
					`PUT_REG_COORD:  coordination_delay <= hwdata_i[15:0];
					`PUT_REG_IRQ_EN: irq_en <= hwdata_i[2:0];
					default:         ;
				endcase
			end
			// Read data is taken at the address phase and stands in the data phase
			if (acc && !hwrite_i)
			begin
				case (haddr_i)
					`PUT_REG_CTRL:     hrdata_o <= {27'h0, ctrl};
					`PUT_REG_EXTEND:   hrdata_o <= {16'h0, extend_time};
					`PUT_REG_COORD:    hrdata_o <= {16'h0, coordination_delay};
					`PUT_REG_STATUS:   hrdata_o <= {24'h0, trip_o, phase_trip_out_o,
						send_permit_o, send_permit_phase_o};
					`PUT_REG_IRQ_STAT: hrdata_o <= {29'h0, irq_stat};
					`PUT_REG_IRQ_EN:   hrdata_o <= {29'h0, irq_en};
					default:           hrdata_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // put_teleprot

`default_nettype wire

// >>> verification/put_remote.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end relays: each end enabled in en_i answers our permit one cycle later
module put_remote (
	// Clock
	input  wire logic       clk_i,
	// Local side
	input  wire logic       send_i,
	input  wire logic [1:0] en_i,
	// Remote permits
	output var  logic       end1_o,
	output var  logic       end2_o
);
	// One permit feeds both channels of a three-end line
	always @(posedge clk_i)
		{end2_o, end1_o} <= {2{send_i}} & en_i;
endmodule // put_remote
`default_nettype wire

// >>> verification/put_checker.sv
`timescale 1ns/1ps
`default_nettype none
module put_checker (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	// Bus
	input wire logic        hsel_i,
	input wire logic [11:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic        hready_i,
	input wire logic [31:0] hwdata_i,
	// Line side
	input wire logic        short_zone_trip_in_i,
	input wire logic [2:0]  short_zone_trip_phase_in_i,
	input wire logic        recv_permit_end1_i,
	input wire logic        send_permit_o,
	input wire logic [2:0]  send_permit_phase_o,
	input wire logic        recv_end1_o,
	input wire logic        trip_o,
	input wire logic [2:0]  phase_trip_out_o,
	input wire logic        return_en_o,
	input wire logic        weak_trip_en_o,
	input wire logic        irq_o
);
	logic        wq;
	logic [11:0] aq;
	logic [4:0]  ctl;
	// Shadow of the control word, so rules can be gated by mode
	always @(posedge clk_i)
	begin
		wq <= !sys_rst_i && hsel_i && htrans_i[1] && hwrite_i && hready_i;
		aq <= haddr_i;
		if (sys_rst_i)
			ctl <= 5'h00;
		else if (wq && aq == 12'h000)
			ctl <= hwdata_i[4:0];
	end
	wire uon = ctl[2:0] == 3'h1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_send; (uon && short_zone_trip_in_i) [*3] |-> ##[0:3] send_permit_o; endproperty
	a_send: assert property (p_send) else $error("send late");
	property p_ph;
		(uon && short_zone_trip_phase_in_i[1]) [*3] |-> ##[0:3] send_permit_phase_o[1];
	endproperty
	a_ph: assert property (p_ph) else $error("phase send late");
	property p_or;
		(uon && short_zone_trip_phase_in_i[2]) [*3] |-> ##[0:3] send_permit_o;
	endproperty
	a_or: assert property (p_or) else $error("or send late");
	property p_off; (!ctl[0]) [*4] |-> !send_permit_o && !trip_o && !recv_end1_o; endproperty
	a_off: assert property (p_off) else $error("active while off");
	property p_echo; (uon && recv_permit_end1_i) [*4] |-> recv_end1_o; endproperty
	a_echo: assert property (p_echo) else $error("no echo");
	property p_gen; |phase_trip_out_o |-> ##[0:2] trip_o; endproperty
	a_gen: assert property (p_gen) else $error("no general trip");
	property p_ret; ctl[0] |-> return_en_o == ctl[3]; endproperty
	a_ret: assert property (p_ret) else $error("return decode");
	property p_wtr; ctl[0] |-> weak_trip_en_o == ctl[4]; endproperty
	a_wtr: assert property (p_wtr) else $error("weak decode");
	c_trip: cover property (trip_o && phase_trip_out_o == 3'h1);
	c_irq: cover property (irq_o);
	c_drop: cover property ($fell(send_permit_o));
endmodule // put_checker
bind put_teleprot put_checker u_put_checker (.*);
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
	logic        hsel_i = 1'b0, hwrite_i = 1'b0;
	logic [11:0] haddr_i = 12'h000;
	logic [1:0]  htrans_i = 2'h0, far_en = 2'h0;
	logic [2:0]  hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0, rd;
	logic        short_zone_trip_in_i = 1'b0, long_zone_pickup_in_i = 1'b0;
	logic [2:0]  short_zone_trip_phase_in_i = 3'h0, long_zone_pickup_phase_in_i = 3'h0;
	logic [5:0]  rpp = 6'h00;
	wire  [31:0] hrdata_o;
	wire         hreadyout_o, hresp_o, recv_permit_end1_i, recv_permit_end2_i;
	wire         send_permit_o, recv_end1_o, recv_end2_o, trip_o, irq_o;
	wire         return_en_o, weak_trip_en_o;
	wire  [2:0]  send_permit_phase_o, recv_end1_phase_o, recv_end2_phase_o, phase_trip_out_o;
	int          mismatches = 0, cmp_count = 0, i;
	put_teleprot #(.TICK_CYC(10)) u_put_teleprot (.hready_i(hreadyout_o),
		.recv_permit_end1_phase_i(rpp[2:0]), .recv_permit_end2_phase_i(rpp[5:3]), .*);
	put_remote u_put_remote (.clk_i(clk_i), .send_i(send_permit_o), .en_i(far_en),
		.end1_o(recv_permit_end1_i), .end2_o(recv_permit_end2_i));
	always #5 clk_i = ~clk_i;
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Single word transfer; waits on hready, never on a fixed count
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		begin
			// Select stays high between transfers; an idle htrans marks the gap
			hsel_i <= 1'b1;
			haddr_i <= a;
			htrans_i <= 2'h2;
			hwrite_i <= w;
			@(posedge clk_i);
			while (hreadyout_o !== 1'b1) @(posedge clk_i);
			htrans_i <= 2'h0;
			hwdata_i <= d;
			@(posedge clk_i);
			while (hreadyout_o !== 1'b1) @(posedge clk_i);
			rd = hrdata_o;
		end
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		begin
			cmp_count++;
			if (g !== e)
				$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
			if (g !== e)
				mismatches++;
		end
	endtask
	task finish_test;
		begin
			$display("Compares %0d, mismatches %0d", cmp_count, mismatches);
			if (mismatches == 0 && cmp_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial
	begin
		#20000;
		mismatches++;
		finish_test;
	end
	initial
	begin
		cyc(8);
		sys_rst_i <= 1'b0;
		cyc(1);
		xfer(1'h0, 12'h000, 32'h0); chk(rd, 32'h0);
		xfer(1'h0, 12'h020, 32'h0); chk(rd, 32'h0); chk(hresp_o, 1'h0);
		xfer(1'h1, 12'h004, 32'h2);
		xfer(1'h0, 12'h004, 32'h0); chk(rd, 32'h2);
		xfer(1'h1, 12'h000, 32'h1);
		// A short pulse must still leave a full-length permit
		short_zone_trip_in_i <= 1'b1;
		cyc(3);
		short_zone_trip_in_i <= 1'b0;
		cyc(8); chk(send_permit_o, 1'h1);
		cyc(40); chk(send_permit_o, 1'h0);
		for (i = 0; i < 3; i++)
		begin
			short_zone_trip_phase_in_i <= 3'h1 << i;
			cyc(6); chk({send_permit_o, send_permit_phase_o}, {1'h1, 3'h1 << i});
			short_zone_trip_phase_in_i <= 3'h0;
			cyc(40);
		end
		long_zone_pickup_in_i <= 1'b1;
		long_zone_pickup_phase_in_i <= 3'h1;
		for (i = 1; i < 3; i++)
		begin
			far_en <= i[1:0];
			short_zone_trip_in_i <= 1'b1;
			cyc(14); chk({trip_o, phase_trip_out_o}, 4'h9);
			chk({recv_end2_o, recv_end1_o}, i[1:0]);
			short_zone_trip_in_i <= 1'b0;
			cyc(50);
		end
		far_en <= 2'h0;
		long_zone_pickup_phase_in_i <= 3'h7;
		for (i = 0; i < 6; i++)
		begin
			rpp <= 6'h1 << i;
			cyc(8); chk(phase_trip_out_o, 3'h1 << (i % 3));
			chk({recv_end2_phase_o, recv_end1_phase_o}, 6'h1 << i);
			chk(trip_o, 1'h1);
			rpp <= 6'h0;
			cyc(6);
		end
		xfer(1'h1, 12'h008, 32'h2);
		rpp <= 6'h1;
		cyc(8); chk(trip_o, 1'h0);
		cyc(40); chk(trip_o, 1'h1);
		rpp <= 6'h0;
		xfer(1'h1, 12'h008, 32'h0);
		short_zone_trip_in_i <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			xfer(1'h1, 12'h000, (i << 3) | ((i % 3) << 1) | 1);
			cyc(8); chk({send_permit_o, weak_trip_en_o, return_en_o}, {i % 3 == 0, i[1:0]});
		end
		xfer(1'h0, 12'h00c, 32'h0); chk(rd, 32'h8);
		// Events are sticky: mask, unmask, then clear
		xfer(1'h1, 12'h014, 32'h0);
		cyc(2); chk(irq_o, 1'h0);
		xfer(1'h0, 12'h010, 32'h0); chk(rd & 32'h7, 32'h7);
		xfer(1'h1, 12'h014, 32'h2);
		cyc(2); chk(irq_o, 1'h1);
		xfer(1'h1, 12'h018, 32'h7);
		cyc(2); chk(irq_o, 1'h0);
		xfer(1'h0, 12'h010, 32'h0); chk(rd, 32'h0);
		// A stall in mid-prolongation must not shorten the permit
		short_zone_trip_in_i <= 1'b0;
		cyc(4);
		ce_i <= 1'b0;
		cyc(40); chk(send_permit_o, 1'h1);
		ce_i <= 1'b1;
		cyc(40); chk(send_permit_o, 1'h0);
		short_zone_trip_in_i <= 1'b1;
		cyc(6); chk(send_permit_o, 1'h1);
		xfer(1'h1, 12'h000, 32'h0);
		cyc(6); chk(send_permit_o, 1'h0);
		short_zone_trip_in_i <= 1'b0;
		finish_test;
	end
endmodule // tb_top
`default_nettype wire
